// ==== core/sync_io_pins.sv ====
/*
   two configurable sync/io pins: sync function, level input or driven output.
   assumes pins arrive asynchronously, are pulled high outside, and software
   reaches the registers over a plain strobe port on the same clock.
*/
module sync_io_pins
   import sync_io_pkg::*;
(
   input  wire logic                          I_CLOCK,
   input  wire logic                          I_NRST,
   input  wire logic [sync_io_pkg::ADDR_W-1:0] I_ADDR,
   input  wire logic [sync_io_pkg::DATA_W-1:0] I_WDATA,
   input  wire logic                          I_WR,
   input  wire logic                          I_RD,
   output logic      [sync_io_pkg::DATA_W-1:0] O_RDATA,
   input  wire logic [sync_io_pkg::NPIN-1:0]   I_PIN,
   output logic      [sync_io_pkg::NPIN-1:0]   O_PIN,
   output logic      [sync_io_pkg::NPIN-1:0]   O_PIN_OE,
   output logic                               O_OUTPUT_ON
);
   import sync_io_pkg::*;

   // logic value to pin level: logic 1 is low unless flipped
   function automatic logic level_of(input logic value, input logic flip);
      level_of = ~(value ^ flip);
   endfunction : level_of

   pin_cfg_t               cfg_reg   [NPIN];
   pwm_cfg_t               pwm_reg   [NPIN];
   logic                   en_reg;
   logic                   en_next;
   logic [DATA_W-1:0]      rdata_reg;
   logic [DATA_W-1:0]      rdata_next;
   logic [NPIN-1:0]        pin_reg;
   logic [NPIN-1:0]        oe_reg;
   logic [NPIN-1:0]        level_reg;
   logic [NPIN-1:0]        detect;
   logic [NPIN-1:0]        emit_start;
   logic [NPIN-1:0]        pin_next;
   logic [NPIN-1:0]        oe_next;
   logic [NPIN-1:0]        level_next;

   // write strobe aimed at one register address,
   // shared by the global and the per-pin decodes
   function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
      wr_hit = wr && (addr == target);
   endfunction : wr_hit

   // register decode
   wire wr_cfg    = wr_hit(I_WR, I_ADDR, ADDR_CFG);
   wire wr_enable = wr_hit(I_WR, I_ADDR, ADDR_ENABLE);
   wire sync_on   = (cfg_reg[PIN_ON].func == FUNC_SYNC) && detect[PIN_ON];
   wire sync_off  = (cfg_reg[PIN_OFF].func == FUNC_SYNC) && detect[PIN_OFF];

   // software command first, then peer pulses act on the current state
   assign en_next = wr_enable ? I_WDATA[0] :
                    (!en_reg && sync_on)  ? 1'b1 :
                    (en_reg && sync_off)  ? 1'b0 :
                    en_reg;

   // pulse requests on state edges
   assign emit_start[PIN_ON]  = en_next && !en_reg;
   assign emit_start[PIN_OFF] = !en_next && en_reg;

   // read mux, unmapped addresses read zero
   always_comb
   begin
      rdata_next = '0;
      if (I_RD)
      begin
         case (I_ADDR)
            ADDR_CFG:
            begin
               rdata_next[CFG_FIELD_W-1:0] = cfg_reg[0];
               rdata_next[CFG_PIN_STRIDE +: CFG_FIELD_W] = cfg_reg[1];
            end
            ADDR_ENABLE:    rdata_next[0] = en_reg;
            ADDR_LEVEL:     rdata_next[NPIN-1:0] = level_reg;
            ADDR_PWM_RATE0: rdata_next[PWM_W-1:0] = pwm_reg[0].rate;
            ADDR_PWM_DUTY0: rdata_next[PWM_W-1:0] = pwm_reg[0].duty;
            ADDR_PWM_RATE1: rdata_next[PWM_W-1:0] = pwm_reg[1].rate;
            ADDR_PWM_DUTY1: rdata_next[PWM_W-1:0] = pwm_reg[1].duty;
            default:        rdata_next = '0;
         endcase
      end
   end

   // output state; off after reset so no pulse
   // leaves the block before software or a peer turn-on pulse turns it on
   always_ff @(posedge I_CLOCK or negedge I_NRST)
   begin
      if (!I_NRST)
         en_reg <= 1'b0;
      else
         en_reg <= en_next;
   end

   // read answer stands one cycle, then falls back
   // to zero because the strobe is gone
   always_ff @(posedge I_CLOCK or negedge I_NRST)
   begin
      if (!I_NRST)
         rdata_reg <= '0;
      else
         rdata_reg <= rdata_next;
   end

   // pin drive and sampled level; released and high
   // after reset, matching the outside pull-up
   always_ff @(posedge I_CLOCK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         pin_reg   <= '1;
         oe_reg    <= '0;
         level_reg <= '0;
      end
      else
      begin
         pin_reg   <= pin_next;
         oe_reg    <= oe_next;
         level_reg <= level_next;
      end
   end

   // per-pin logic: both pins are alike, only their
   // place in the output state machine differs
   // (bit 0 turns the output on, bit 1 turns it off)
   for (genvar i = 0; i < NPIN; i++)
   begin : g_pin
      logic             meta_reg;
      logic             sync_reg;
      logic [CNT_W-1:0] low_cnt_reg;
      logic [CNT_W-1:0] low_cnt_next;
      logic [CNT_W-1:0] tx_cnt_reg;
      logic [CNT_W-1:0] guard_cnt_reg;
      logic [PWM_W-1:0] pwm_cnt_reg;
      logic             hit_reg;

      wire [ADDR_W-1:0] rate_addr = ADDR_PWM_RATE0 + ADDR_W'(8 * i);
      wire [ADDR_W-1:0] duty_addr = ADDR_PWM_DUTY0 + ADDR_W'(8 * i);
      wire asserted  = (sync_reg == cfg_reg[i].flip);
      wire tx_active = (tx_cnt_reg != '0);
      wire quiet     = tx_active || (guard_cnt_reg != '0);
      // rate 0 and 1 both wrap every cycle; compare one bit wider so
      // that rate 0 cannot underflow into a very long period
      wire pwm_wrap  = (({1'b0, pwm_cnt_reg} + (PWM_W+1)'(1)) >= {1'b0, pwm_reg[i].rate});
      // sync emission only where this pin runs its sync function
      wire emit_here = emit_start[i] && (cfg_reg[i].func == FUNC_SYNC);
      wire pwm_bit   = (pwm_cnt_reg < pwm_reg[i].duty);

      // qualified low counter, held in reset while own pulse settles
      assign low_cnt_next = (quiet || !asserted) ? '0 :
                            (low_cnt_reg == MIN_LOW_CNT) ? low_cnt_reg :
                            low_cnt_reg + CNT_W'(1);
      // one detect per qualified pulse; a held low
      // does not detect again until it is released
      assign detect[i] = (low_cnt_next == MIN_LOW_CNT) && !hit_reg;
      assign level_next[i] = asserted;

      // pin drive by function
      always_comb
      begin
         case (cfg_reg[i].func)
            FUNC_SYNC:
            begin
               oe_next[i]  = tx_active || emit_start[i];
               pin_next[i] = level_of(1'b1, cfg_reg[i].flip);
            end
            FUNC_OUTPUT:
            begin
               oe_next[i] = 1'b1;
               case (cfg_reg[i].val)
                  VAL_TRUE:  pin_next[i] = level_of(1'b1, cfg_reg[i].flip);
                  VAL_PWM:   pin_next[i] = level_of(pwm_bit, cfg_reg[i].flip);
                  default:   pin_next[i] = level_of(1'b0, cfg_reg[i].flip);
               endcase
            end
            default:
            begin
               oe_next[i]  = 1'b0;
               pin_next[i] = 1'b1;
            end
         endcase
      end

      // two-flop synchroniser, idle high like the pulled-up wire;
      // only the second flop feeds any logic
      always_ff @(posedge I_CLOCK or negedge I_NRST)
      begin
         if (!I_NRST)
         begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
         end
         else
         begin
            meta_reg <= I_PIN[i];
            sync_reg <= meta_reg;
         end
      end

      // pin config and pwm settings, written by software only;
      // a new config takes effect on the following cycle
      always_ff @(posedge I_CLOCK or negedge I_NRST)
      begin
         if (!I_NRST)
         begin
            cfg_reg[i] <= CFG_RESET;
            pwm_reg[i] <= '{rate: PWM_RATE_RESET, duty: PWM_DUTY_RESET};
         end
         else
         begin
            if (wr_cfg)
               cfg_reg[i] <= pin_cfg_t'(I_WDATA[i*CFG_PIN_STRIDE +: CFG_FIELD_W]);
            if (wr_hit(I_WR, I_ADDR, rate_addr))
               pwm_reg[i].rate <= I_WDATA[PWM_W-1:0];
            if (wr_hit(I_WR, I_ADDR, duty_addr))
               pwm_reg[i].duty <= I_WDATA[PWM_W-1:0];
         end
      end

      // qualified low count; hit holds off a second detect
      // until the wire has been released once
      always_ff @(posedge I_CLOCK or negedge I_NRST)
      begin
         if (!I_NRST)
         begin
            low_cnt_reg <= '0;
            hit_reg     <= 1'b0;
         end
         else
         begin
            low_cnt_reg <= low_cnt_next;
            hit_reg     <= (low_cnt_next == MIN_LOW_CNT);
         end
      end

      // emitted pulse lasts one cycle beyond the qualified minimum, then a guard
      // covers the slow rise so the block never hears itself
      always_ff @(posedge I_CLOCK or negedge I_NRST)
      begin
         if (!I_NRST)
         begin
            tx_cnt_reg    <= '0;
            guard_cnt_reg <= '0;
         end
         else
         begin
            if (emit_here)
               tx_cnt_reg <= MIN_LOW_CNT;
            else if (tx_active)
               tx_cnt_reg <= tx_cnt_reg - CNT_W'(1);
            if (tx_active)
               guard_cnt_reg <= GUARD_CNT;
            else if (guard_cnt_reg != '0)
               guard_cnt_reg <= guard_cnt_reg - CNT_W'(1);
         end
      end

      // free-running pwm period counter, runs in every mode
      // so a switch into pwm output starts mid-period
      always_ff @(posedge I_CLOCK or negedge I_NRST)
      begin
         if (!I_NRST)
            pwm_cnt_reg <= '0;
         else
            pwm_cnt_reg <= pwm_wrap ? '0 : pwm_cnt_reg + PWM_W'(1);
      end
   end

   // every output comes straight from a flip-flop
   assign O_RDATA     = rdata_reg;
   assign O_PIN       = pin_reg;
   assign O_PIN_OE    = oe_reg;
   assign O_OUTPUT_ON = en_reg;

endmodule : sync_io_pins

// ==== core/sync_io_pkg.sv ====
/*
   constants and types for the two configurable rear-panel sync/io pins.
   assumes a single 20 MHz clock and a plain address/strobe register port.
*/
package sync_io_pkg;

   // clock and pulse timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int MIN_LOW_NS    = 30000;           // least low width of a sync pulse
   localparam int RISE_NS       = 10000;           // slowest pin rise after release
   localparam int MIN_LOW_CYC   = (MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GUARD_CYC     = (RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 10;
   localparam logic [CNT_W-1:0] MIN_LOW_CNT = CNT_W'(MIN_LOW_CYC);
   localparam logic [CNT_W-1:0] GUARD_CNT   = CNT_W'(GUARD_CYC);

   // pins and register bus
   localparam int NPIN   = 2;
   localparam int PIN_ON = 0;                      // turn-on sync pin
   localparam int PIN_OFF = 1;                     // turn-off sync pin
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PWM_W  = 16;

   // register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_CFG       = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE    = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_LEVEL     = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_PWM_RATE0 = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_PWM_DUTY0 = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_PWM_RATE1 = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_PWM_DUTY1 = 8'h1c;

   // field layout of the config register: one byte per pin
   localparam int CFG_PIN_STRIDE = 8;
   localparam int CFG_FIELD_W    = 5;

   typedef enum logic [1:0] {
      FUNC_SYNC   = 2'b00,
      FUNC_INPUT  = 2'b01,
      FUNC_OUTPUT = 2'b10
   } pin_func_t;

   typedef enum logic [1:0] {
      VAL_FALSE = 2'b00,
      VAL_TRUE  = 2'b01,
      VAL_PWM   = 2'b10
   } out_val_t;

   typedef struct packed {
      out_val_t  val;      // bits 4:3
      logic      flip;     // bit 2, polarity_flipped when set
      pin_func_t func;     // bits 1:0
   } pin_cfg_t;

   localparam pin_cfg_t CFG_RESET = '{val: VAL_FALSE, flip: 1'b0, func: FUNC_SYNC};
   localparam logic [PWM_W-1:0] PWM_RATE_RESET = 16'h0000;
   localparam logic [PWM_W-1:0] PWM_DUTY_RESET = 16'h0000;

   typedef struct packed {
      logic [PWM_W-1:0] rate;   // period in clock cycles
      logic [PWM_W-1:0] duty;   // cycles at logic 1 per period
   } pwm_cfg_t;

endpackage : sync_io_pkg

// ==== test/sync_io_pins_sva.sv ====
/*
   checker of pulse timing and pulse causes of the sync/io pins, and of the pin levels of pin 0 only.
   assumes it is bound to sync_io_pins; it shadows config writes itself.
*/
module sync_io_pins_sva
   import sync_io_pkg::*;
(
   input wire logic                            I_CLOCK,
   input wire logic                            I_NRST,
   input wire logic [sync_io_pkg::ADDR_W-1:0] I_ADDR,
   input wire logic [sync_io_pkg::DATA_W-1:0] I_WDATA,
   input wire logic                            I_WR,
   input wire logic [sync_io_pkg::NPIN-1:0]   I_PIN,
   input wire logic [sync_io_pkg::NPIN-1:0]   O_PIN,
   input wire logic [sync_io_pkg::NPIN-1:0]   O_PIN_OE,
   input wire logic                            O_OUTPUT_ON
);
   pin_cfg_t    c0_reg;
   pin_cfg_t    c1_reg;
   logic        wcfg_reg;
   logic [15:0] n0_reg;
   logic [15:0] n1_reg;
   wire         cfg_wr = I_WR && I_ADDR == ADDR_CFG;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_NRST);
   // shadow config and length of each drive stretch
   always_ff @(posedge I_CLOCK or negedge I_NRST)
      if (!I_NRST)
      begin
         c0_reg   <= CFG_RESET;
         c1_reg   <= CFG_RESET;
         wcfg_reg <= 1'b0;
         n0_reg   <= '0;
         n1_reg   <= '0;
      end
      else
      begin
         c0_reg   <= cfg_wr ? pin_cfg_t'(I_WDATA[4:0]) : c0_reg;
         c1_reg   <= cfg_wr ? pin_cfg_t'(I_WDATA[12:8]) : c1_reg;
         wcfg_reg <= cfg_wr;
         n0_reg   <= O_PIN_OE[0] ? n0_reg + 16'd1 : 16'd0;
         n1_reg   <= O_PIN_OE[1] ? n1_reg + 16'd1 : 16'd0;
      end
   on_width_a: assert property ($fell(O_PIN_OE[0]) && c0_reg.func == FUNC_SYNC && !$past(wcfg_reg)
      |-> n0_reg == 16'(MIN_LOW_CYC + 1)) else $error("turn-on pulse width wrong");
   off_width_a: assert property ($fell(O_PIN_OE[1]) && c1_reg.func == FUNC_SYNC && !$past(wcfg_reg)
      |-> n1_reg == 16'(MIN_LOW_CYC + 1)) else $error("turn-off pulse width wrong");
   on_emit_a: assert property ($rose(O_OUTPUT_ON) && c0_reg.func == FUNC_SYNC
      |-> O_PIN_OE[0] && O_PIN[0] == c0_reg.flip) else $error("no pulse at turn-on");
   off_emit_a: assert property ($fell(O_OUTPUT_ON) && c1_reg.func == FUNC_SYNC
      |-> O_PIN_OE[1] && O_PIN[1] == c1_reg.flip) else $error("no pulse at turn-off");
   on_cause_a: assert property ($rose(O_OUTPUT_ON) && !$past(I_WR)
      |-> $past(I_PIN[0], 3) == c0_reg.flip && $past(I_PIN[0], 500) == c0_reg.flip) else $error("turn-on unprompted");
   off_cause_a: assert property ($fell(O_OUTPUT_ON) && !$past(I_WR)
      |-> $past(I_PIN[1], 3) == c1_reg.flip && $past(I_PIN[1], 500) == c1_reg.flip) else $error("turn-off unprompted");
   out_level_a: assert property (c0_reg.func == FUNC_OUTPUT && c0_reg.val != VAL_PWM && !wcfg_reg
      |-> O_PIN_OE[0] && O_PIN[0] == ((c0_reg.val != VAL_TRUE) ^ c0_reg.flip)) else $error("output level wrong");
   in_release_a: assert property (c0_reg.func == FUNC_INPUT && !wcfg_reg |-> !O_PIN_OE[0])
      else $error("input pin driven");
endmodule : sync_io_pins_sva

bind sync_io_pins sync_io_pins_sva sync_io_pins_sva_inst (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_ADDR(I_ADDR),
   .I_WDATA(I_WDATA), .I_WR(I_WR), .I_PIN(I_PIN), .O_PIN(O_PIN), .O_PIN_OE(O_PIN_OE), .O_OUTPUT_ON(O_OUTPUT_ON));

// ==== test/sync_peer.sv ====
/*
   peer instrument: the matching pair of sync pins on open-drain wires.
   assumes the wires are pulled high whenever nobody drives them.
*/
module sync_peer
(
   input  wire logic       i_clock,
   input  wire logic [1:0]  i_fire,
   input  wire logic [15:0] i_len,
   input  wire logic [1:0]  i_oe,
   input  wire logic [1:0]  i_dev,
   output logic      [1:0]  o_wire
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0][15:0] hold_reg = '0;
   // pulls a wire low for the commanded count, 600 or more for a real pulse
   always @(posedge i_clock)
      for (int k = 0; k < 2; k++)
         hold_reg[k] <= i_fire[k] ? i_len : hold_reg[k] - 16'(hold_reg[k] != 0);
   // wired level: peer low wins, released wire floats high
   always_comb
      for (int k = 0; k < 2; k++)
         o_wire[k] = (hold_reg[k] != 0) ? 1'b0 : (i_oe[k] ? i_dev[k] : 1'b1);
endmodule : sync_peer

// ==== test/test_sync_io_pins.sv ====
/*
   self-checking bench of the sync/io pins facing a peer instrument.
   assumes the package, the design, its bound checker and the peer model.
*/
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t %h %h", $time, g, e); end end
module test_sync_io_pins;
   timeunit 1ns;
   timeprecision 1ns;
   import sync_io_pkg::*;
   logic              I_CLOCK = 0, I_NRST = 0, I_WR = 0, I_RD = 0;
   logic [ADDR_W-1:0] I_ADDR = '0;
   logic [DATA_W-1:0] I_WDATA = '0, O_RDATA, d;
   logic [1:0]        I_PIN, O_PIN, O_PIN_OE, fire = '0;
   logic              O_OUTPUT_ON;
   logic [15:0]       len = '0, rt, dt, lows;
   logic [31:0]       rnd = 32'hd430;
   int                errors = 0, n_compared = 0, cyc = 0;
   sync_io_pins sync_io_pins_inst (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
      .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PIN(I_PIN), .O_PIN(O_PIN), .O_PIN_OE(O_PIN_OE),
      .O_OUTPUT_ON(O_OUTPUT_ON));
   sync_peer sync_peer_inst (.i_clock(I_CLOCK), .i_fire(fire), .i_len(len), .i_oe(O_PIN_OE), .i_dev(O_PIN),
      .o_wire(I_PIN));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // low cycles expected over four pwm periods
   function automatic logic [15:0] pwm_lows(input logic [15:0] r, input logic [15:0] u);
      return 16'd4 * ((u >= r) ? r : u);
   endfunction : pwm_lows
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      I_ADDR <= a;
      I_WDATA <= v;
      I_WR <= 1'b1;
      @(posedge I_CLOCK);
      I_WR <= 1'b0;
      @(posedge I_CLOCK);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      I_ADDR <= a;
      I_RD <= 1'b1;
      @(posedge I_CLOCK);
      I_RD <= 1'b0;
      @(posedge I_CLOCK);
      d = O_RDATA;
   endtask : rd
   // peer pulls pin k low for n cycles; returns w cycles after the firing cycle
   task automatic pulse(input int k, input logic [15:0] n, input int w);
      len <= n;
      fire[k] <= 1'b1;
      @(posedge I_CLOCK);
      fire[k] <= 1'b0;
      repeat (w) @(posedge I_CLOCK);
   endtask : pulse
   task automatic test_done;
      if (errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   initial forever #25 I_CLOCK = ~I_CLOCK;
   // hang guard
   always @(posedge I_CLOCK)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         test_done();
      end
   end
   initial
   begin
      repeat (6) @(posedge I_CLOCK);
      I_NRST <= 1'b1;
      rd(ADDR_CFG);
      `CHK({d, O_PIN_OE}, 34'h0)
      wr(ADDR_ENABLE, 32'h1);
      `CHK({O_OUTPUT_ON, O_PIN_OE, O_PIN[0]}, 4'b1010)
      pulse(0, 16'd0, 900);
      pulse(0, 16'd650, 1500);
      `CHK({O_OUTPUT_ON, O_PIN_OE}, 3'b100)
      pulse(1, 16'd300, 900);
      `CHK(O_OUTPUT_ON, 1'b1)
      pulse(1, 16'd650, 1500);
      `CHK({O_OUTPUT_ON, O_PIN_OE}, 3'b000)
      pulse(1, 16'd650, 1500);
      `CHK({O_OUTPUT_ON, O_PIN_OE}, 3'b000)
      pulse(0, 16'd650, 1500);
      `CHK(O_OUTPUT_ON, 1'b1)
      wr(ADDR_ENABLE, 32'h0);
      `CHK({O_OUTPUT_ON, O_PIN_OE, O_PIN[1]}, 4'b0100)
      pulse(1, 16'd0, 900);
      wr(ADDR_ENABLE, 32'h1);
      pulse(1, 16'd0, 50);
      wr(ADDR_ENABLE, 32'h0);
      pulse(1, 16'd0, 900);
      `CHK(O_OUTPUT_ON, 1'b0)
      wr(ADDR_CFG, 32'h101);
      pulse(0, 16'd100, 40);
      rd(ADDR_LEVEL);
      `CHK({d[1:0], O_PIN_OE}, 4'b0100)
      wr(ADDR_CFG, 32'h105);
      pulse(0, 16'd0, 100);
      rd(ADDR_LEVEL);
      `CHK(d[1:0], 2'b01)
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_CFG, {19'h0, 1'b0, i[1], i[0], FUNC_OUTPUT, 3'h0, 1'b0, i[1], i[0], FUNC_OUTPUT});
         repeat (2) @(posedge I_CLOCK);
         `CHK({O_PIN_OE, O_PIN}, {2'b11, {2{~(i[1] ^ i[0])}}})
      end
      repeat (3)
      begin
         rnd = lfsr(rnd);
         rt = 16'd2 + 16'(rnd[4:0]);
         dt = 16'(rnd[12:8]) % (rt + 16'd1);
         wr(ADDR_PWM_RATE0, {16'h0, rt});
         wr(ADDR_PWM_DUTY0, {16'h0, dt});
         wr(ADDR_CFG, 32'h12);
         repeat (40) @(posedge I_CLOCK);
         lows = '0;
         repeat (4 * rt) @(posedge I_CLOCK) lows += 16'(!O_PIN[0]);
         `CHK(lows, pwm_lows(rt, dt))
      end
      test_done();
   end
endmodule : test_sync_io_pins
